// File: core/dma_chan_map.svh
// Register offsets, field positions, reset values and timing counts for
// one DMA channel's control and status block.
// Assumes a 32-bit AXI4-Lite register port with word-aligned registers.
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH

`define CHANNEL_CONTROL_OFS 12'h100
`define CHANNEL_STATE_FLAGS_OFS 12'h104
`define COUNT_REFILL_REG_OFS 12'h11C
`define INT_STATUS_OFS 12'h120
`define INT_MASK_OFS 12'h124
`define XFER_COUNT_OFS 12'h128

`define CTL_EN_BIT 0
`define CTL_RLDEN_BIT 1
`define CTL_PRI_LO 2
`define CTL_REQ_LO 4
`define CTL_HOLD_BIT 10
`define CTL_PER_LO 11
`define CTL_PRESC_LO 14
`define CTL_DIS_IE_BIT 30
`define CTL_CTZ_IE_BIT 31
`define CTL_WMASK 32'hC000FFFF

`define STA_ACTIVE_BIT 0
`define STA_IPEND_BIT 1
`define STA_CTZ_BIT 2
`define STA_RLD_BIT 3
`define STA_BUSERR_BIT 4
`define STA_EXPIRY_BIT 6

`define CNTRLD_RLDEN_BIT 31
`define CTL_RESET 32'h00000000
`define PRESC_SHIFT_1 8
`define PRESC_SHIFT_2 16
`define PRESC_SHIFT_3 24
`define EXPIRY_BASE 3

`endif

// File: core/dma_chan_pkg.sv
// Types shared by the DMA channel control and status block.
// Assumes the constants header is included by the design file.
package dma_chan_pkg;
   typedef struct packed {
      logic ctz_ie;
      logic dis_ie;
      logic [1:0] expiry_prescale_sel;
      logic [2:0] expiry_period_sel;
      logic expiry_hold_off;
      logic [5:0] request_sel;
      logic [1:0] priority_lvl;
      logic reload_en;
      logic enable;
   } chan_ctl_t;

   typedef struct packed {
      logic expiry_flag;
      logic bus_error;
      logic reload_flag;
      logic ctz_flag;
   } chan_flags_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_TIMING = 3'b100
   } expiry_state_t;
endpackage

// File: core/dma_chan_ctrl.sv
// One DMA channel's control/status registers, expiry timer, arbitration
// request and transfer counter with reload, behind an AXI4-Lite slave.
// Assumes the data mover and arbiter on the same clock; abort and beat
// inputs are single-cycle pulses from that logic.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dma_chan_map.svh"

module dma_chan_ctrl
   import dma_chan_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int CHAN_ID = 0,
   parameter int CNT_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CHANNELS*2-1:0] peer_priority,
   input wire logic [CHANNELS-1:0] peer_request,
   input wire logic beat_done,
   input wire logic [2:0] beat_bytes,
   input wire logic bus_abort,
   input wire logic [31:0] src_reload,
   input wire logic [31:0] dst_reload,
   output logic grant,
   output logic [5:0] request_sel,
   output logic reload_pulse,
   output logic [31:0] src_load_addr,
   output logic [31:0] dst_load_addr,
   output logic irq
);

   // ---------------------------------------------------------------
   // AXI4-Lite write and read channels
   // ---------------------------------------------------------------
   logic aw_held, w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire do_read = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Byte-lane merge used by the control and reload registers and the flag clears; mask and count writes ignore the strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            old[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return old;
   endfunction

   wire wr_ctl = do_write && aw_addr == `CHANNEL_CONTROL_OFS;
   wire wr_sta = do_write && aw_addr == `CHANNEL_STATE_FLAGS_OFS;
   wire wr_rld = do_write && aw_addr == `COUNT_REFILL_REG_OFS;
   wire wr_ist = do_write && aw_addr == `INT_STATUS_OFS;
   wire wr_msk = do_write && aw_addr == `INT_MASK_OFS;
   wire wr_cnt = do_write && aw_addr == `XFER_COUNT_OFS;
   wire wr_known = wr_ctl || wr_sta || wr_rld || wr_ist || wr_msk || wr_cnt;
   wire [31:0] ones_written = w_data & merge(32'h0, 32'hFFFFFFFF, w_strb);

   // ---------------------------------------------------------------
   // Control register and transfer counter
   // ---------------------------------------------------------------
   chan_ctl_t ctl;
   logic [31:0] ctl_word;
   logic [CNT_W-1:0] count, refill;
   logic active, active_q;
   chan_flags_t flags;
   assign ctl_word = {ctl.ctz_ie, ctl.dis_ie, 14'h0,
      ctl.expiry_prescale_sel, ctl.expiry_period_sel, ctl.expiry_hold_off,
      ctl.request_sel, ctl.priority_lvl, ctl.reload_en, ctl.enable};

   wire [31:0] ctl_merged = merge(ctl_word, w_data, w_strb) & `CTL_WMASK;
   wire [31:0] rld_merged = merge({ctl.reload_en, 7'h0,
      24'(refill)}, w_data, w_strb);
   wire [CNT_W-1:0] beat_w = CNT_W'(beat_bytes);
   wire ctz_event = active && beat_done && count <= beat_w;
   wire do_reload = ctz_event && ctl.reload_en;
   wire expiry_event;
   wire status_fall = active_q && !active;

   // Channel stays active while enabled; it stops at count-to-zero
   // without reload, on abort or on expiry.
   assign active = ctl.enable;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl <= chan_ctl_t'(`CTL_RESET);
         count <= '0;
         refill <= '0;
         active_q <= 1'b0;
      end else if (clk_en) begin
         active_q <= active;
         if (wr_ctl && !active) begin
            ctl <= chan_ctl_t'({ctl_merged[31:30], ctl_merged[15:0]});
         end else if (wr_ctl) begin
            ctl.enable <= ctl_merged[`CTL_EN_BIT];
         end
         if (wr_rld) begin
            refill <= rld_merged[CNT_W-1:0];
            ctl.reload_en <= rld_merged[`CNTRLD_RLDEN_BIT];
         end
         if (wr_cnt && !active) begin
            count <= w_data[CNT_W-1:0];
         end else if (do_reload) begin
            count <= refill;
         end else if (active && beat_done) begin
            count <= ctz_event ? '0 : count - beat_w;
         end
         // Abort, expiry and a final count-to-zero stop the channel
         if (bus_abort || expiry_event || (ctz_event && !ctl.reload_en)) begin
            ctl.enable <= 1'b0;
         end
         if (status_fall) begin
            ctl.enable <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Expiry timer
   // ---------------------------------------------------------------
   expiry_state_t tstate;
   logic [23:0] prescale;
   logic [9:0] ticks;
   wire [4:0] presc_shift = ctl.expiry_prescale_sel == 2'd1 ?
      5'(`PRESC_SHIFT_1) : ctl.expiry_prescale_sel == 2'd2 ?
      5'(`PRESC_SHIFT_2) : 5'(`PRESC_SHIFT_3);
   wire [23:0] presc_last = 24'((32'h1 << presc_shift) - 1);
   wire presc_tick = prescale == presc_last;
   wire [9:0] tick_limit = 10'((`EXPIRY_BASE + 1) << ctl.expiry_period_sel)
      - 10'h1;
   assign expiry_event = tstate == ST_TIMING && presc_tick &&
      ticks == tick_limit;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tstate <= ST_IDLE;
         prescale <= 24'h000000;
         ticks <= 10'h000;
      end else if (clk_en) begin
         unique case (tstate)
            ST_IDLE: begin
               prescale <= 24'h000000;
               ticks <= 10'h000;
               if (active && ctl.expiry_prescale_sel != 2'd0) begin
                  tstate <= ctl.expiry_hold_off ? ST_ARMED : ST_TIMING;
               end
            end
            ST_ARMED: begin
               if (!active) begin
                  tstate <= ST_IDLE;
               end else if (beat_done) begin
                  tstate <= ST_TIMING;
               end
            end
            ST_TIMING: begin
               // A beat restarts the window: only idle periods expire
               if (!active || ctl.expiry_prescale_sel == 2'd0) begin
                  tstate <= ST_IDLE;
               end else if (beat_done || expiry_event) begin
                  prescale <= 24'h000000;
                  ticks <= 10'h000;
               end else if (presc_tick) begin
                  prescale <= 24'h000000;
                  ticks <= ticks + 10'h001;
               end else begin
                  prescale <= prescale + 24'h000001;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Status flags and interrupt
   // ---------------------------------------------------------------
   logic [3:0] int_mask;
   wire [3:0] flag_set = {expiry_event, bus_abort, do_reload, ctz_event};
   wire [3:0] flag_clr = wr_sta ? {ones_written[`STA_EXPIRY_BIT],
      ones_written[`STA_BUSERR_BIT], ones_written[`STA_RLD_BIT],
      ones_written[`STA_CTZ_BIT]} : wr_ist ? ones_written[3:0] : 4'h0;
   wire [3:0] next_flags = (flags & ~flag_clr) |
      flag_set;
   wire ipend = (flags.ctz_flag && ctl.ctz_ie) ||
      (flags.expiry_flag || flags.bus_error) && ctl.dis_ie;

   // ---------------------------------------------------------------
   // Arbitration: lower priority code wins, ties rotate
   // ---------------------------------------------------------------
   logic [CHANNELS-1:0] rr_last;
   logic [CHANNELS-1:0] beats_me;
   int rr_last_idx;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_peer
         wire [1:0] pp = peer_priority[g*2 +: 2];
         // Equal level: a peer ahead of us in rotation after the last winner
         wire ahead = ((g - rr_last_idx + 2*CHANNELS - 1) % CHANNELS) <
            ((CHAN_ID - rr_last_idx + 2*CHANNELS - 1) % CHANNELS);
         assign beats_me[g] = g != CHAN_ID && peer_request[g] &&
            (pp < ctl.priority_lvl || (pp == ctl.priority_lvl && ahead));
      end
   endgenerate
   always_comb begin
      rr_last_idx = 0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (rr_last[i]) begin
            rr_last_idx = i;
         end
      end
   end
   wire want = active && peer_request[CHAN_ID];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
         int_mask <= 4'h0;
         irq <= 1'b0;
         grant <= 1'b0;
         rr_last <= '0;
         request_sel <= 6'h00;
         reload_pulse <= 1'b0;
         src_load_addr <= 32'h00000000;
         dst_load_addr <= 32'h00000000;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
         s_axi_bresp <= 2'b00;
      end else if (clk_en) begin
         flags <= next_flags;
         if (wr_msk) begin
            int_mask <= w_data[3:0];
         end
         irq <= |(flags & int_mask);
         grant <= want && beats_me == '0;
         if (|peer_request) begin
            // Peers share the same request view, so last winner tracks all
            for (int i = 0; i < CHANNELS; i++) begin
               if (peer_request[i] && rr_last_idx != i) begin
                  rr_last <= CHANNELS'(1) << i;
               end
            end
         end
         request_sel <= ctl.request_sel;
         reload_pulse <= do_reload;
         if (do_reload) begin
            src_load_addr <= src_reload;
            dst_load_addr <= dst_reload;
         end
         if (do_write) begin
            s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
         end
         if (do_read) begin
            s_axi_rresp <= 2'b00;
            unique case (s_axi_araddr)
               `CHANNEL_CONTROL_OFS: s_axi_rdata <= ctl_word;
               `CHANNEL_STATE_FLAGS_OFS: s_axi_rdata <= {25'h0,
                  flags.expiry_flag, 1'b0, flags.bus_error,
                  flags.reload_flag, flags.ctz_flag, ipend, active};
               `COUNT_REFILL_REG_OFS: s_axi_rdata <= {ctl.reload_en, 7'h0,
                  24'(refill)};
               `INT_STATUS_OFS: s_axi_rdata <= {28'h0, flags};
               `INT_MASK_OFS: s_axi_rdata <= {28'h0, int_mask};
               `XFER_COUNT_OFS: s_axi_rdata <= 32'(count);
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
      end
   end

endmodule

// File: dv/far_side_model.sv
// Far side of one DMA channel: data mover beats, bus aborts, reload
// register values and the request and priority lines of the channels.
// Assumes the bench calls its tasks from a process timed by aclk.
`timescale 1ns/1ps

module far_side_model #(
   parameter int CHANNELS = 4
) (
   input wire logic aclk,
   output logic beat_done,
   output logic [2:0] beat_bytes,
   output logic bus_abort,
   output logic [31:0] src_reload,
   output logic [31:0] dst_reload,
   output logic [CHANNELS*2-1:0] peer_priority,
   output logic [CHANNELS-1:0] peer_request
);
   initial begin
      beat_done = 1'b0;
      beat_bytes = 3'h0;
      bus_abort = 1'b0;
      src_reload = 32'h10000000;
      dst_reload = 32'h20000000;
      peer_priority = '0;
      peer_request = '0;
   end

   // Byte lines are not held after the beat, so stale values never help
   task automatic beat(input logic [2:0] b);
      @(posedge aclk);
      beat_done <= 1'b1;
      beat_bytes <= b;
      @(posedge aclk);
      beat_done <= 1'b0;
      beat_bytes <= ~b;
   endtask

   task automatic abort();
      @(posedge aclk);
      bus_abort <= 1'b1;
      @(posedge aclk);
      bus_abort <= 1'b0;
   endtask

   task automatic peers(input logic [CHANNELS*2-1:0] p,
                        input logic [CHANNELS-1:0] r);
      @(posedge aclk);
      peer_priority <= p;
      peer_request <= r;
   endtask
endmodule

// File: dv/dma_chan_checker.sv
// Concurrent checks on the ports of one DMA channel block.
// Assumes one clock domain and reload values held stable by the far side.
`timescale 1ns/1ps

module dma_chan_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [31:0] src_reload,
   input wire logic [31:0] dst_reload,
   input wire logic reload_pulse,
   input wire logic [31:0] src_load_addr,
   input wire logic [31:0] dst_load_addr,
   input wire logic grant,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response not released");
   a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read response not released");
   a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
      s_axi_rdata == 32'h0) else $error("error read carries data");
   a_src_load: assert property (reload_pulse |->
      src_load_addr == src_reload)
      else $error("source reload value wrong");
   a_dst_load: assert property (reload_pulse |->
      dst_load_addr == dst_reload)
      else $error("destination reload value wrong");
   a_reload_once: assert property (reload_pulse |=> !reload_pulse)
      else $error("reload pulse too long");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !grant &&
      !reload_pulse && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
endmodule

bind dma_chan_ctrl dma_chan_checker chk_i (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .src_reload, .dst_reload,
   .reload_pulse, .src_load_addr, .dst_load_addr, .grant, .irq);

// File: dv/tb_top.sv
// Self-checking bench for one DMA channel control and status block.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_top;
   localparam int LIMIT = 20000;
   logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, beat_done, bus_abort;
   logic grant, reload_pulse, irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, src_reload, dst_reload, rv;
   logic [31:0] src_load_addr, dst_load_addr;
   logic [3:0] s_axi_wstrb, peer_request;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [2:0] beat_bytes;
   logic [5:0] request_sel;
   logic [7:0] peer_priority;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;

   dma_chan_ctrl #(.CHANNELS(4), .CHAN_ID(0), .CNT_W(24)) dut (.aclk,
      .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .peer_priority, .peer_request, .beat_done, .beat_bytes,
      .bus_abort, .src_reload, .dst_reload, .grant, .request_sel,
      .reload_pulse, .src_load_addr, .dst_load_addr, .irq);
   far_side_model #(.CHANNELS(4)) pm (.aclk, .beat_done, .beat_bytes,
      .bus_abort, .src_reload, .dst_reload, .peer_priority, .peer_request);

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic finish_test();
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Register bus master
   // ----------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      rd(a, rv, rr);
      chk(rv, e);
   endtask

   // Counts cycles until the interrupt line is seen high, up to lim
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rchk(12'h100, 32'h0);
      rchk(12'h104, 32'h0);
      rd(12'h200, rv, rr);
      chk({rv[29:0], rr}, 32'h2);
      wr(12'h200, 32'h0);
      chk({30'h0, rr}, 32'h2);
   endtask

   task automatic t_config();
      wr(12'h100, 32'h000002A6);
      rchk(12'h100, 32'h000002A6);
      chk({26'h0, request_sel}, 32'h2A);
      // Only byte lane 0 is written; the upper lanes keep their value
      s_axi_wstrb <= 4'h1;
      wr(12'h100, 32'h0000FF00);
      s_axi_wstrb <= 4'hF;
      rchk(12'h100, 32'h00000200);
      wr(12'h100, 32'h000002A6);
      wr(12'h11C, 32'h00000008);
      rchk(12'h100, 32'h000002A4);
      wr(12'h11C, 32'h80000008);
      rchk(12'h100, 32'h000002A6);
   endtask

   task automatic t_ctz();
      wr(12'h124, 32'h3);
      wr(12'h128, 32'h4);
      wr(12'h100, 32'h800002A7);
      rchk(12'h104, 32'h1);
      pm.beat(3'h4);
      n = 0;
      while (reload_pulse !== 1'b1 && n < 8) begin
         @(posedge aclk);
         n++;
      end
      chk({31'h0, reload_pulse}, 32'h1);
      chk(src_load_addr, 32'h10000000);
      chk(dst_load_addr, 32'h20000000);
      rchk(12'h128, 32'h8);
      rchk(12'h120, 32'h3);
      rchk(12'h104, 32'hF);
      chk({31'h0, irq}, 32'h1);
      wr(12'h104, 32'h0);
      rchk(12'h104, 32'hF);
      wr(12'h124, 32'h0);
      rchk(12'h104, 32'hF);
      chk({31'h0, irq}, 32'h0);
      wr(12'h124, 32'h3);
      wr(12'h104, 32'hC);
      rchk(12'h104, 32'h1);
      rchk(12'h120, 32'h0);
      // A beat while the clock enable is low must leave the count alone
      @(posedge aclk);
      clk_en <= 1'b0;
      pm.beat(3'h4);
      clk_en <= 1'b1;
      rchk(12'h128, 32'h8);
   endtask

   task automatic t_abort();
      pm.abort();
      rchk(12'h104, 32'h10);
      rchk(12'h100, 32'h800002A6);
      wr(12'h104, 32'h10);
      rchk(12'h104, 32'h0);
   endtask

   // Prescale 1 is 256 cycles a tick; period 0 is four ticks
   task automatic t_expiry();
      wr(12'h124, 32'h8);
      wr(12'h100, 32'h40004001);
      wait_irq(1200);
      chk({31'h0, irq}, 32'h1);
      chk(32'(n > 500 && n < 1100), 32'h1);
      rchk(12'h104, 32'h42);
      wr(12'h104, 32'h40);
      rchk(12'h104, 32'h0);
      wr(12'h100, 32'h00004401);
      wait_irq(1300);
      chk({31'h0, irq}, 32'h0);
      pm.beat(3'h1);
      wait_irq(1200);
      chk({31'h0, irq}, 32'h1);
      wr(12'h104, 32'h40);
      wr(12'h100, 32'h00000001);
      wait_irq(1300);
      chk({31'h0, irq}, 32'h0);
      wr(12'h100, 32'h0);
   endtask

   task automatic t_arb();
      wr(12'h100, 32'h0000000C);
      wr(12'h100, 32'h0000000D);
      pm.peers(8'h03, 4'b0011);
      repeat (4) @(posedge aclk);
      chk({31'h0, grant}, 32'h0);
      pm.peers(8'h03, 4'b0001);
      repeat (4) @(posedge aclk);
      chk({31'h0, grant}, 32'h1);
      // Equal levels: the grant must alternate with the peer
      pm.peers(8'hFF, 4'b0011);
      repeat (4) @(posedge aclk);
      n = 0;
      repeat (8) begin
         @(posedge aclk);
         if (grant === 1'b1) n++;
      end
      chk(n, 32'h4);
      pm.peers(8'h00, 4'b0000);
      wr(12'h100, 32'h0);
   endtask

   initial begin
      aresetn = 1'b0;
      clk_en = 1'b1;
      s_axi_awaddr = 12'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_config();
      t_ctz();
      t_abort();
      t_expiry();
      t_arb();
      finish_test();
   end

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         finish_test();
      end
   end
endmodule
